/* File: rtl/spfmc_consts.svh */
// Constants for the setpoint, frequency and mode control block.
// Assumes a single 125 MHz reference clock and 32-bit APB data.
`ifndef SPFMC_CONSTS_SVH
`define SPFMC_CONSTS_SVH
`define SPF_CLK_MHZ 125
`define SPF_SS0_US 500
`define SPF_SS1_US 1000
`define SPF_SS2_US 2000
`define SPF_SS3_US 4000
`define SPF_SLEW0_NS 500
`define SPF_SLEW1_NS 1000
`define SPF_SLEW2_NS 5000
`define SPF_SLEW3_NS 10000
`define SPF_CEIL_CYC(ns) (((ns) * `SPF_CLK_MHZ + 999) / 1000)
`define SPF_FREQ0_KHZ 12'h5dc
`define SPF_FREQ1_KHZ 12'h8ca
`define SPF_FREQ2_KHZ 12'h9c4
`define SPF_FREQ3_KHZ 12'hbb8
`define SPF_BASE_LO_UV 22'h061a80
`define SPF_BASE_HI_UV 22'h0c3500
`define SPF_STEP0_UV 22'h0004e2
`define SPF_STEP1_UV 22'h0009c4
`define SPF_STEP2_UV 22'h001388
`define SPF_STEP3_UV 22'h002710
`define SPF_RANGE_TOP 2'h3
`define SPF_RANGE_RESET 2'h2
`define SPF_SSTIME_RESET 2'h1
`define SPF_SLEW_RESET 2'h0
`define SPF_OFF_CTRL1 12'h000
`define SPF_OFF_SETPT 12'h004
`define SPF_OFF_CTRL2 12'h008
`define SPF_OFF_STATUS 12'h00c
`define SPF_OFF_ADDR 12'h010
`define SPF_C1_SLEW_LO 2
`define SPF_C1_FPWM 4
`define SPF_C1_SPREAD 5
`define SPF_TRI_HALF 6'sh10
`define SPF_TRI_SHIFT 4
`define SPF_EDGE_SAT 2'h3
`define SPF_SYNC_EDGES 2'h2
`endif

/* File: rtl/spfmc_pkg.sv */
// Types for the setpoint, frequency and mode control block.
// Assumes the constants header is compiled alongside.
package spfmc_pkg;
	// Strap digitizer sequence
	typedef enum logic [1:0] {
		ST_MSB = 2'b00,
		ST_LSB = 2'b01,
		ST_LOAD = 2'b10,
		ST_DONE = 2'b11
	} spfmc_strap_t;
endpackage

/* File: rtl/spfmc_top.sv */
// Setpoint, switching frequency and mode control with APB registers.
// Assumes strap buffers, enable and mode pins are asynchronous inputs.
// Function
// [RQ1] Frequency strap selects one of four frequencies
// [RQ2] Upper bit sampled with both switches open
// [RQ3] Upper zero: close pullup, read lower bit
// [RQ4] Upper one: close pulldown, read lower bit
// [RQ5] Voltage strap uses the same sequence
// [RQ6] Range field picks step and base
// [RQ7] Range applies only after setpoint write
// [RQ8] Target equals base plus code times step
// [RQ9] No serial variant fixes the 5 mV range
// [RQ10] Strap state loads default setpoint code
// [RQ11] Strap state sets the bus address
// [RQ12] Writes deferred until soft start ends
// [RQ13] Ramp to captured code, then new one
// [RQ14] Writes while disabled apply at next enable
// [RQ15] Startup ramps to strap target first
// [RQ16] Dynamic scaling steps one code per tick
// [RQ17] Static mode level picks PWM or power save
// [RQ18] Valid sync clock forces PWM, aligns cycles
// [RQ19] Forced PWM is pin OR register bit
// [RQ20] Spread spectrum: triangle, ten percent deviation
// [RQ21] Spread needs enable bit and no sync
// [RQ22] Spreading primary uses internal clock only
// [RQ23] Spread enable forces PWM operation
// [RQ24] Enable pin held low during initialization
// [RQ25] Strap bits form codes 00 to 11
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "spfmc_consts.svh"
module spfmc_top import spfmc_pkg::*; #(
	parameter bit HAS_SERIAL = 1'b1,
	parameter int SETTLE_CYCLES = 16,
	parameter int SS0_CYCLES = `SPF_SS0_US * `SPF_CLK_MHZ,
	parameter int SS1_CYCLES = `SPF_SS1_US * `SPF_CLK_MHZ,
	parameter int SS2_CYCLES = `SPF_SS2_US * `SPF_CLK_MHZ,
	parameter int SS3_CYCLES = `SPF_SS3_US * `SPF_CLK_MHZ,
	parameter int SPREAD_STEP_CYCLES = 64,
	parameter int SYNC_WINDOW = 255,
	parameter logic [6:0] BUS_ADDR_BASE = 7'h40, // Arbitrary value
	parameter logic [7:0] DEF_SET_GND = 8'h46,
	parameter logic [7:0] DEF_SET_RGND = 8'h5a,
	parameter logic [7:0] DEF_SET_RVIN = 8'h78,
	parameter logic [7:0] DEF_SET_VIN = 8'h5f
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic freqStrapPin,
	output logic freqPullupSwitch,
	output logic freqPulldownSwitch,
	input wire logic voltStrapPin,
	output logic voltPullupSwitch,
	output logic voltPulldownSwitch,
	input wire logic enPinIn,
	output logic enPinOut,
	output logic enPinOe,
	input wire logic modeClockPin,
	output logic converterEnable,
	output logic softStartActive,
	output logic [7:0] targetCode,
	output logic [21:0] targetUv,
	output logic [11:0] switchFreqKhz,
	output logic pwmForced,
	output logic powerSave,
	output logic spreadActive,
	output logic syncPulse,
	output logic [6:0] busTargetAddr
);
	localparam logic [10:0] SLEW_CYC0 = 11'(`SPF_CEIL_CYC(`SPF_SLEW0_NS));
	localparam logic [10:0] SLEW_CYC1 = 11'(`SPF_CEIL_CYC(`SPF_SLEW1_NS));
	localparam logic [10:0] SLEW_CYC2 = 11'(`SPF_CEIL_CYC(`SPF_SLEW2_NS));
	localparam logic [10:0] SLEW_CYC3 = 11'(`SPF_CEIL_CYC(`SPF_SLEW3_NS));

	// Nominal frequency per strap code
	function automatic logic [11:0] freqOf(input logic [1:0] code);
		case (code)
			2'h0: freqOf = `SPF_FREQ0_KHZ;
			2'h1: freqOf = `SPF_FREQ1_KHZ;
			2'h2: freqOf = `SPF_FREQ2_KHZ;
			default: freqOf = `SPF_FREQ3_KHZ;
		endcase
	endfunction

	// Default setpoint per voltage strap code
	function automatic logic [7:0] defaultSet(input logic [1:0] code);
		case (code)
			2'h0: defaultSet = DEF_SET_GND;
			2'h1: defaultSet = DEF_SET_RGND;
			2'h2: defaultSet = DEF_SET_RVIN;
			default: defaultSet = DEF_SET_VIN;
		endcase
	endfunction

	// Soft-start length in cycles
	function automatic logic [19:0] ssCycles(input logic [1:0] sel);
		case (sel)
			2'h0: ssCycles = 20'(SS0_CYCLES);
			2'h1: ssCycles = 20'(SS1_CYCLES);
			2'h2: ssCycles = 20'(SS2_CYCLES);
			default: ssCycles = 20'(SS3_CYCLES);
		endcase
	endfunction

	// Cycles per setpoint step
	function automatic logic [10:0] slewCycles(input logic [1:0] sel);
		case (sel)
			2'h0: slewCycles = SLEW_CYC0;
			2'h1: slewCycles = SLEW_CYC1;
			2'h2: slewCycles = SLEW_CYC2;
			default: slewCycles = SLEW_CYC3;
		endcase
	endfunction

	// Target in microvolts for a range and code
	function automatic logic [21:0] calcUv(input logic [1:0] rng, input logic [7:0] code);
		logic [21:0] step;
		logic [21:0] base;
		step = `SPF_STEP3_UV;
		base = (rng == `SPF_RANGE_TOP) ? `SPF_BASE_HI_UV : `SPF_BASE_LO_UV;
		case (rng)
			2'h0: step = `SPF_STEP0_UV;
			2'h1: step = `SPF_STEP1_UV;
			2'h2: step = `SPF_STEP2_UV;
			default: step = `SPF_STEP3_UV;
		endcase
		calcUv = 22'(base + 22'(code) * step);
	endfunction

	// Spread frequency: nominal plus tenth times idx over half span
	function automatic logic [11:0] spreadKhz(input logic [11:0] nom, input logic signed [5:0] idx);
		logic signed [15:0] dev;
		logic signed [31:0] prod;
		dev = signed'({4'h0, 12'(nom / 12'h00a)});
		prod = 32'(dev * signed'({{10{idx[5]}}, idx}));
		spreadKhz = 12'(signed'({4'h0, nom}) + 16'(prod >>> `SPF_TRI_SHIFT));
	endfunction

	logic [3:0] pinS1; // First stage, read only by second stage
	logic [3:0] pinS2;
	logic [3:0] pinS3;
	logic [3:0] pinStable; // Filtered pin levels: freq, volt, en, mode
	spfmc_strap_t state;
	logic [7:0] settleCnt;
	logic freqMsb;
	logic voltMsb;
	logic [1:0] freqCode;
	logic [1:0] voltCode;
	logic initDone;
	logic [1:0] rangeReg; // Written range, not yet in use
	logic [1:0] slewReg;
	logic [1:0] ssTimeReg;
	logic fpwmReg; // Forced PWM bit
	logic spreadReg; // Spread enable bit
	logic [7:0] setpointReg;
	logic setPending; // Setpoint written, not yet applied
	logic rangeArm; // A real setpoint write arrived since the last apply
	logic apbWrite;
	logic setWrite;
	logic applySet;
	logic enPrev;
	logic enabled;
	logic enRise;
	logic dvsPhase;
	logic [7:0] captureCode;
	logic [7:0] appliedSet;
	logic [1:0] appliedRange;
	logic [1:0] appliedSlew;
	logic ssActive;
	logic [19:0] ssCnt;
	logic [7:0] ssTarget;
	logic [10:0] slewCnt;
	logic slewTick;
	logic modeLevel;
	logic modePrev;
	logic modeRise;
	logic [7:0] winCnt;
	logic [1:0] edgeCnt;
	logic syncPresent;
	logic [7:0] triCnt;
	logic signed [5:0] triIdx;
	logic triUp;

	// Three-stage synchronizers; a level counts once stages two and three agree
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pinS1 <= 4'h0;
			pinS2 <= 4'h0;
			pinS3 <= 4'h0;
			pinStable <= 4'h0;
		end else begin
			pinS1 <= {modeClockPin, enPinIn, voltStrapPin, freqStrapPin};
			pinS2 <= pinS1;
			pinS3 <= pinS2;
			pinStable <= (pinS2 & pinS3) | (pinStable & (pinS2 ^ pinS3));
		end
	end

	// Strap digitizer: both pins decoded in parallel, same steps
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state <= ST_MSB;
			settleCnt <= 8'h00;
			freqMsb <= 1'b0;
			voltMsb <= 1'b0;
			freqCode <= 2'h0;
			voltCode <= 2'h0;
		end else begin
			case (state)
				ST_MSB: begin
					// Switches open; settle covers the synchronizer delay
					if (settleCnt == 8'(SETTLE_CYCLES - 1)) begin
						freqMsb <= pinStable[0]; // [RQ2]
						voltMsb <= pinStable[1]; // [RQ5]
						settleCnt <= 8'h00;
						state <= ST_LSB;
					end else begin
						settleCnt <= settleCnt + 8'h01;
					end
				end
				ST_LSB: begin
					// Either switch: the buffer level is the lower bit
					if (settleCnt == 8'(SETTLE_CYCLES - 1)) begin
						freqCode <= {freqMsb, pinStable[0]}; // [RQ3] [RQ4] [RQ25]
						voltCode <= {voltMsb, pinStable[1]}; // [RQ5] [RQ25]
						settleCnt <= 8'h00;
						state <= ST_LOAD;
					end else begin
						settleCnt <= settleCnt + 8'h01;
					end
				end
				ST_LOAD: state <= ST_DONE;
				default: state <= ST_DONE;
			endcase
		end
	end

	assign initDone = (state == ST_DONE);
	// Switch drive follows the upper bit during the lower-bit step
	assign freqPullupSwitch = (state == ST_LSB) && !freqMsb; // [RQ3]
	assign freqPulldownSwitch = (state == ST_LSB) && freqMsb; // [RQ4]
	assign voltPullupSwitch = (state == ST_LSB) && !voltMsb; // [RQ5]
	assign voltPulldownSwitch = (state == ST_LSB) && voltMsb; // [RQ5]
	// Enable pulled low until straps and defaults are in
	assign enPinOut = 1'b0;
	assign enPinOe = !initDone; // [RQ24]

	// Bus address from voltage strap, caught once at load
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			busTargetAddr <= 7'h00;
		end else if (state == ST_LOAD) begin
			busTargetAddr <= BUS_ADDR_BASE | {5'h00, voltCode}; // [RQ11]
		end
	end

	// Bus ignores writes until initialization completes
	assign apbWrite = psel && penable && pwrite && initDone;
	assign setWrite = apbWrite && (paddr == `SPF_OFF_SETPT);
	assign pready = 1'b1;

	// Software registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rangeReg <= `SPF_RANGE_RESET; // [RQ6]
			slewReg <= `SPF_SLEW_RESET;
			ssTimeReg <= `SPF_SSTIME_RESET;
			fpwmReg <= 1'b0;
			spreadReg <= 1'b0;
			setpointReg <= 8'h00;
		end else if (state == ST_LOAD) begin
			setpointReg <= defaultSet(voltCode); // [RQ10]
		end else if (apbWrite) begin
			if (paddr == `SPF_OFF_CTRL1) begin
				// Range is fixed when there is no serial interface
				if (HAS_SERIAL) begin
					rangeReg <= pwdata[1:0]; // [RQ9]
				end
				slewReg <= pwdata[`SPF_C1_SLEW_LO +: 2];
				fpwmReg <= pwdata[`SPF_C1_FPWM];
				spreadReg <= pwdata[`SPF_C1_SPREAD];
			end else if (paddr == `SPF_OFF_SETPT) begin
				setpointReg <= pwdata[7:0];
			end else if (paddr == `SPF_OFF_CTRL2) begin
				ssTimeReg <= pwdata[1:0];
			end
		end
	end

	// Read data and error latched in the setup phase
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= 1'b0;
			if (paddr == `SPF_OFF_CTRL1) begin
				prdata <= {26'h0, spreadReg, fpwmReg, slewReg, rangeReg};
			end else if (paddr == `SPF_OFF_SETPT) begin
				prdata <= {24'h0, setpointReg};
			end else if (paddr == `SPF_OFF_CTRL2) begin
				prdata <= {30'h0, ssTimeReg};
			end else if (paddr == `SPF_OFF_STATUS) begin
				prdata <= {16'h0, targetCode, spreadActive, pwmForced, ssActive, initDone,
					voltCode, freqCode};
			end else if (paddr == `SPF_OFF_ADDR) begin
				prdata <= {25'h0, busTargetAddr};
			end else begin
				// Unmapped address answers zero with an error
				prdata <= 32'h0;
				pslverr <= 1'b1;
			end
		end
	end

	assign enabled = initDone && pinStable[2];
	assign enRise = enabled && !enPrev;
	assign dvsPhase = enabled && !ssActive;
	// Pending setpoint is used whenever one waits
	assign captureCode = setPending ? setpointReg : appliedSet;
	// Applied at enable, or while running outside soft start
	assign applySet = setPending && (enRise || dvsPhase); // [RQ12] [RQ14]

	// Enable edge tracking
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			enPrev <= 1'b0;
		end else begin
			enPrev <= enabled;
		end
	end

	// Pending flag: a new write wins over the clear
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			setPending <= 1'b0;
		end else if (setWrite || (state == ST_LOAD)) begin
			setPending <= 1'b1; // [RQ7]
		end else if (applySet) begin
			setPending <= 1'b0;
		end
	end

	// Range gate: the strap load is pending too, but must not carry a range along
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rangeArm <= 1'b0;
		end else if (setWrite) begin
			rangeArm <= 1'b1; // [RQ7]
		end else if (applySet) begin
			rangeArm <= 1'b0;
		end
	end

	// Values the converter actually uses
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			appliedSet <= 8'h00;
			appliedRange <= `SPF_RANGE_RESET;
			appliedSlew <= `SPF_SLEW_RESET;
		end else begin
			if (applySet) begin
				appliedSet <= setpointReg;
			end
			// Range moves only after a real setpoint write
			if (applySet && rangeArm) begin
				appliedRange <= HAS_SERIAL ? rangeReg : `SPF_RANGE_RESET; // [RQ7] [RQ9]
			end
			if (enRise || dvsPhase) begin
				appliedSlew <= slewReg; // [RQ14]
			end
		end
	end

	// Soft-start timer; target frozen at its start
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ssActive <= 1'b0;
			ssCnt <= 20'h0;
			ssTarget <= 8'h00;
		end else if (!enabled) begin
			ssActive <= 1'b0;
		end else if (enRise) begin
			ssActive <= 1'b1;
			ssCnt <= ssCycles(ssTimeReg); // [RQ14]
			ssTarget <= captureCode; // [RQ13] [RQ15]
		end else if (ssActive) begin
			if (ssCnt <= 20'h1) begin
				ssActive <= 1'b0;
			end
			ssCnt <= ssCnt - 20'h1;
		end
	end

	// Step timer for dynamic scaling
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			slewCnt <= 11'h0;
			slewTick <= 1'b0;
		end else if (!dvsPhase) begin
			slewCnt <= 11'h0;
			slewTick <= 1'b0;
		end else if (slewCnt >= slewCycles(appliedSlew) - 11'h1) begin
			slewCnt <= 11'h0;
			slewTick <= 1'b1;
		end else begin
			slewCnt <= slewCnt + 11'h1;
			slewTick <= 1'b0;
		end
	end

	// Target code: soft-start value, then one step per tick
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			targetCode <= 8'h00;
		end else if (!enabled) begin
			targetCode <= 8'h00;
		end else if (enRise) begin
			targetCode <= captureCode; // [RQ15]
		end else if (ssActive) begin
			targetCode <= ssTarget; // [RQ13]
		end else if (slewTick && (targetCode < appliedSet)) begin
			targetCode <= targetCode + 8'h01; // [RQ16]
		end else if (slewTick && (targetCode > appliedSet)) begin
			targetCode <= targetCode - 8'h01; // [RQ16]
		end
	end

	// Voltage from range and code, registered
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			targetUv <= 22'h0;
		end else begin
			targetUv <= calcUv(appliedRange, targetCode); // [RQ6] [RQ8]
		end
	end

	assign converterEnable = enabled;
	assign softStartActive = ssActive;
	assign modeLevel = pinStable[3];
	assign modeRise = modeLevel && !modePrev;
	assign syncPresent = (edgeCnt >= `SPF_SYNC_EDGES);

	// Sync clock detect: enough edges inside a sliding window
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			modePrev <= 1'b0;
			winCnt <= 8'h00;
			edgeCnt <= 2'h0;
		end else begin
			modePrev <= modeLevel;
			if (modeRise) begin
				winCnt <= 8'h00;
				if (edgeCnt != `SPF_EDGE_SAT) begin
					edgeCnt <= edgeCnt + 2'h1;
				end
			end else if (winCnt == 8'(SYNC_WINDOW - 1)) begin
				// Static level: edges stop, sync is dropped
				winCnt <= 8'h00;
				edgeCnt <= 2'h0;
			end else begin
				winCnt <= winCnt + 8'h01;
			end
		end
	end

	// Operating mode selection
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pwmForced <= 1'b0;
			powerSave <= 1'b1;
			spreadActive <= 1'b0;
			syncPulse <= 1'b0;
		end else begin
			pwmForced <= modeLevel || fpwmReg || syncPresent || spreadReg; // [RQ19] [RQ23]
			powerSave <= !(modeLevel || fpwmReg || syncPresent || spreadReg); // [RQ17]
			// External clock wins; the spreading part runs on its own oscillator
			spreadActive <= spreadReg && !syncPresent; // [RQ21] [RQ22]
			syncPulse <= modeRise && syncPresent; // [RQ18]
		end
	end

	// Triangle sweep across plus and minus half span
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			triCnt <= 8'h00;
			triIdx <= 6'sh00;
			triUp <= 1'b1;
		end else if (!spreadActive) begin
			triCnt <= 8'h00;
			triIdx <= 6'sh00;
			triUp <= 1'b1;
		end else if (triCnt == 8'(SPREAD_STEP_CYCLES - 1)) begin
			triCnt <= 8'h00;
			if (triUp) begin
				triIdx <= triIdx + 6'sh01; // [RQ20]
				triUp <= (triIdx < (`SPF_TRI_HALF - 6'sh01));
			end else begin
				triIdx <= triIdx - 6'sh01; // [RQ20]
				triUp <= (triIdx <= (6'sh01 - `SPF_TRI_HALF));
			end
		end else begin
			triCnt <= triCnt + 8'h01;
		end
	end

	// Switching frequency, modulated while spreading
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			switchFreqKhz <= `SPF_FREQ0_KHZ;
		end else if (spreadActive) begin
			switchFreqKhz <= spreadKhz(freqOf(freqCode), triIdx); // [RQ20]
		end else begin
			switchFreqKhz <= freqOf(freqCode); // [RQ1]
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence sEnRise;
		enabled && !enPrev;
	endsequence
	sequence sSoftHeld;
		ssActive ##1 ssActive;
	endsequence

	AST_EN_HOLD: assert property (!initDone |-> enPinOe && !enPinOut) // [RQ24]
		else $error("enable not held low during init");
	AST_MSB_OPEN: assert property (state == ST_MSB |-> !(freqPullupSwitch ||
		freqPulldownSwitch || voltPullupSwitch || voltPulldownSwitch)) // [RQ2]
		else $error("switch closed in upper-bit step");
	AST_LSB_SWITCH: assert property (state == ST_LSB |-> (freqPullupSwitch == !freqMsb) &&
		(freqPulldownSwitch == freqMsb) && (voltPullupSwitch == !voltMsb)) // [RQ3]
		else $error("wrong switch in lower-bit step");
	AST_LOAD_DEF: assert property (state == ST_LOAD |=> setpointReg == defaultSet(voltCode) &&
		busTargetAddr == (BUS_ADDR_BASE | {5'h00, voltCode})) // [RQ10]
		else $error("default setpoint or address not loaded");
	AST_FREQ: assert property (initDone && !spreadActive |=>
		switchFreqKhz == freqOf(freqCode)) // [RQ1]
		else $error("frequency does not match strap");
	AST_SS_HOLD: assert property (sSoftHeld |-> $stable(appliedRange) && $stable(appliedSet) &&
		$stable(targetCode)) // [RQ12]
		else $error("value changed during soft start");
	AST_SS_START: assert property (sEnRise |=> ssActive && ssTarget == $past(captureCode)) // [RQ13]
		else $error("soft start target not captured");
	AST_DVS: assert property (dvsPhase && $past(dvsPhase) && $changed(targetCode) |->
		$past(slewTick)) // [RQ16]
		else $error("target stepped without slew tick");
	AST_RANGE_LATE: assert property ($changed(appliedRange) |-> $past(applySet)) // [RQ7]
		else $error("range applied without setpoint write");
	AST_RANGE_FIX: assert property (!HAS_SERIAL |-> appliedRange == `SPF_RANGE_RESET) // [RQ9]
		else $error("range not fixed");
	AST_UV: assert property (!sys_rst |=> targetUv ==
		calcUv($past(appliedRange), $past(targetCode))) // [RQ8]
		else $error("target voltage mismatch");
	AST_FPWM: assert property (modeLevel || fpwmReg |=> pwmForced && !powerSave) // [RQ19]
		else $error("forced PWM not selected");
	AST_PSM: assert property (!(modeLevel || fpwmReg || syncPresent || spreadReg) |=>
		powerSave) // [RQ17]
		else $error("power save not selected");
	AST_SYNC: assert property (syncPresent |=> pwmForced && !spreadActive) // [RQ18]
		else $error("sync did not force PWM");
	AST_SPREAD: assert property (spreadReg |=> pwmForced && (spreadActive ||
		$past(syncPresent))) // [RQ23]
		else $error("spread did not force PWM");
	AST_SPREAD_OFF: assert property (!spreadReg |=> !spreadActive) // [RQ21]
		else $error("spread active while disabled");
endmodule

/* File: tb/spfmc_strap_model.sv */
// Resistor model that stands on one strap pin of the control block.
// Assumes a switch output is high while that sensing switch is closed.
`timescale 1ns/1ps
module spfmc_strap_model (
	input wire logic [1:0] strapCode,
	input wire logic pullupOn,
	input wire logic pulldownOn,
	output logic pinLevel
);
	// Codes run from short to ground up to short to supply
	always_comb begin
		case (strapCode)
			2'h0: pinLevel = 1'b0; // A hard short ignores both switches
			2'h1: pinLevel = pullupOn; // Weak resistor down loses to the pullup
			2'h2: pinLevel = !pulldownOn; // Weak resistor up loses to the pulldown
			default: pinLevel = 1'b1;
		endcase
	end
endmodule

/* File: tb/tb_setpoint_frequency_mode_control.sv */
// Self-checking bench for the setpoint, frequency and mode control block.
// Assumes an APB slave that answers in its own time and strap models on both pins.
`timescale 1ns/1ps
`include "spfmc_consts.svh"
module tb_setpoint_frequency_mode_control;
	localparam logic [6:0] ADDR_BASE = 7'h40; // Arbitrary value
	logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, slvErr, seen;
	logic [11:0] paddr, switchFreqKhz, lo, hi;
	logic [31:0] pwdata, prdata, rd;
	logic freqStrapPin, freqPullupSwitch, freqPulldownSwitch;
	logic voltStrapPin, voltPullupSwitch, voltPulldownSwitch;
	logic enPinIn, enPinOut, enPinOe, enDrive, modeClockPin, converterEnable;
	logic softStartActive, pwmForced, powerSave, spreadActive, syncPulse;
	logic [7:0] targetCode;
	logic [21:0] targetUv;
	logic [6:0] busTargetAddr;
	logic [1:0] fCode, vCode;
	logic [11:0] freqTab [4] = '{`SPF_FREQ0_KHZ, `SPF_FREQ1_KHZ, `SPF_FREQ2_KHZ, `SPF_FREQ3_KHZ};
	logic [7:0] setTab [4] = '{8'h46, 8'h5a, 8'h78, 8'h5f};
	int err_total = 0;
	int check_count = 0;
	int n;
	// Open-drain enable wire: the device pull-down wins over the bench
	assign enPinIn = enPinOe ? enPinOut : enDrive;
	spfmc_top #(.SS0_CYCLES(40), .SS1_CYCLES(80), .SPREAD_STEP_CYCLES(2), .SYNC_WINDOW(16),
		.BUS_ADDR_BASE(ADDR_BASE)) i_dut (.ref_clk, .sys_rst, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr, .freqStrapPin, .freqPullupSwitch,
		.freqPulldownSwitch, .voltStrapPin, .voltPullupSwitch, .voltPulldownSwitch, .enPinIn,
		.enPinOut, .enPinOe, .modeClockPin, .converterEnable, .softStartActive, .targetCode,
		.targetUv, .switchFreqKhz, .pwmForced, .powerSave, .spreadActive, .syncPulse,
		.busTargetAddr);
	spfmc_strap_model i_fstrap (.strapCode(fCode), .pullupOn(freqPullupSwitch),
		.pulldownOn(freqPulldownSwitch), .pinLevel(freqStrapPin));
	spfmc_strap_model i_vstrap (.strapCode(vCode), .pullupOn(voltPullupSwitch),
		.pulldownOn(voltPulldownSwitch), .pinLevel(voltStrapPin));
	// Free-running 125 MHz reference
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic chk(input string name, input logic [31:0] seenV, input logic [31:0] exp);
		check_count++;
		if (seenV !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seenV);
		end
	endtask
	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never gets an answer
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		slvErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Bounded wait for a level, judged at the end
	task automatic waitLvl(ref logic s, input logic v, input int lim);
		for (int i = 0; i < lim && s !== v; i++) @(posedge ref_clk);
		chk("level", s, v);
	endtask
	// Cycles until the target code leaves a value
	task automatic waitMove(input logic [7:0] old);
		n = 0;
		while (targetCode === old && n < 100) begin
			@(posedge ref_clk);
			n++;
		end
	endtask
	// Reset with one strap pair, then check decode, defaults and address
	task automatic strapCase(input logic [1:0] c);
		logic [1:0] v;
		v = ~c;
		fCode <= c;
		vCode <= v;
		enDrive <= 1'b0;
		sys_rst <= 1'b1;
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		chk("hold", {enPinOe, enPinOut}, 2'b10);
		waitLvl(enPinOe, 1'b0, 100);
		chk("freq", switchFreqKhz, freqTab[c]);
		chk("addr", busTargetAddr, ADDR_BASE | {5'h00, v});
		apb(1'b0, `SPF_OFF_STATUS, 32'h0);
		chk("codes", rd[3:0], {v, c});
		apb(1'b0, `SPF_OFF_SETPT, 32'h0);
		chk("default", rd, setTab[v]);
		apb(1'b0, `SPF_OFF_CTRL1, 32'h0);
		chk("range", rd[1:0], 2'h2);
	endtask
	// Range alone is held back; soft start freezes the target; then slew steps
	task automatic rampCase();
		apb(1'b1, `SPF_OFF_CTRL1, 32'h3);
		// Shortest soft start, written while disabled, must govern the next enable
		apb(1'b1, `SPF_OFF_CTRL2, 32'h0);
		enDrive <= 1'b1;
		waitLvl(softStartActive, 1'b1, 20);
		chk("en", converterEnable, 1'b1);
		chk("sscode", targetCode, 8'h46);
		apb(1'b1, `SPF_OFF_SETPT, 32'h48);
		repeat (2) @(posedge ref_clk);
		chk("ssuv", targetUv, 22'd750000);
		chk("sshold", targetCode, 8'h46);
		// The longer default soft start would still run past this limit
		waitLvl(softStartActive, 1'b0, 40);
		waitMove(8'h46);
		chk("step1", targetCode, 8'h47);
		waitMove(8'h47);
		chk("tick", n, 63);
		chk("step2", targetCode, 8'h48);
		repeat (3) @(posedge ref_clk);
		chk("uv", targetUv, 22'd1520000);
	endtask
	// Mode pin, forced-PWM bit, spread spectrum and sync clock
	task automatic modeCase();
		modeClockPin <= 1'b1;
		repeat (8) @(posedge ref_clk);
		chk("pinpwm", {pwmForced, powerSave}, 2'b10);
		modeClockPin <= 1'b0;
		repeat (8) @(posedge ref_clk);
		chk("psave", {pwmForced, powerSave}, 2'b01);
		apb(1'b1, `SPF_OFF_CTRL1, 32'h13);
		repeat (3) @(posedge ref_clk);
		chk("bitpwm", {pwmForced, powerSave}, 2'b10);
		apb(1'b1, `SPF_OFF_CTRL1, 32'h23);
		lo = 12'hfff;
		hi = 12'h000;
		repeat (200) begin
			@(posedge ref_clk);
			if (switchFreqKhz < lo) lo = switchFreqKhz;
			if (switchFreqKhz > hi) hi = switchFreqKhz;
		end
		chk("spread", {spreadActive, pwmForced}, 2'b11);
		chk("fmax", hi, 12'd3300);
		chk("fmin", lo, 12'd2700);
		seen = 1'b0;
		repeat (12) begin
			modeClockPin <= ~modeClockPin;
			repeat (4) begin
				@(posedge ref_clk);
				seen = seen | syncPulse;
			end
		end
		chk("sync", {seen, spreadActive, pwmForced}, 3'b101);
		apb(1'b1, `SPF_OFF_CTRL1, 32'h3);
		repeat (40) @(posedge ref_clk);
		chk("off", {spreadActive, pwmForced, powerSave}, 3'b001);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		{sys_rst, psel, penable, pwrite, enDrive, modeClockPin} <= 6'h20;
		paddr <= 12'h000;
		pwdata <= 32'h0;
		{fCode, vCode} <= 4'h0;
		for (int c = 0; c < 4; c++) strapCase(2'(c));
		apb(1'b0, 12'h014, 32'h0);
		chk("slverr", slvErr, 1'b1);
		chk("badrd", rd, 32'h0);
		rampCase();
		modeCase();
		final_report();
	end
	// Watchdog: the whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_total++;
		final_report();
	end
endmodule
